// [rcr_pkg.sv]
// Operation
// - power-on or brown-out: restart 0000h, status and cause flags preset
// - pin reset while running: restart 0000h, clear pin flag only
// - pin reset in sleep: restart 0000h, timeout 1, powerdown 0
// - watchdog: running restarts and clears flags; in sleep resumes PC+1
// - interrupt wake: resume PC+1, timeout 1, powerdown 0, vector if enabled
// - reset instruction: restart 0000h, clear instruction flag only
// - stack overflow with stack reset enabled: restart, set overflow flag
// - stack underflow with stack reset enabled: restart, set underflow flag
// - each reset other than power-on and brown-out updates only the cause flag of its own source
// - hardware returns cause flags to inactive only on power-on or brown-out; software may too
// - software may write flags active; no reset action follows
// - software brown-out enable always read/write; acts only in mode 01
// - brown-out ready reads 1 while detector active, read only
// - unimplemented bits read zero
// - stack flags active high; watchdog, pin, instruction flags active low
package rcr_pkg;

  // ==========================================================
  // register map
  localparam int          ADDR_W        = 3;
  localparam logic [2:0]  OFF_BOR_CTRL  = 3'h0;
  localparam logic [2:0]  OFF_CAUSE     = 3'h1;
  localparam logic [2:0]  OFF_IRQ_STAT  = 3'h2;
  localparam logic [2:0]  OFF_IRQ_MASK  = 3'h3;

  // ==========================================================
  // brown-out control fields
  localparam int          BC_SW_EN      = 7;
  localparam int          BC_RSVD       = 6;
  localparam int          BC_READY      = 0;
  localparam logic        BC_SW_EN_RST  = 1'h1;
  localparam logic        BC_RSVD_RST   = 1'h0;
  localparam logic [1:0]  BMODE_OFF     = 2'h0;
  localparam logic [1:0]  BMODE_SW      = 2'h1;
  localparam logic [1:0]  BMODE_NOSLEEP = 2'h2;
  localparam logic [1:0]  BMODE_ON      = 2'h3;

  // ==========================================================
  // cause flag fields
  localparam int          CF_OVF        = 7;
  localparam int          CF_UNF        = 6;
  localparam int          CF_WDT_N      = 4;
  localparam int          CF_EXT_N      = 3;
  localparam int          CF_RI_N       = 2;
  localparam int          CF_POR_N      = 1;
  localparam int          CF_BOR_N      = 0;
  localparam logic [7:0]  CF_IMPL_MASK  = 8'hdf;
  localparam logic [7:0]  CF_RST        = 8'h1d;

  // ==========================================================
  // interrupt event bits
  localparam int          EV_W          = 8;
  localparam int          EV_POR        = 0;
  localparam int          EV_BOR        = 1;
  localparam int          EV_EXT        = 2;
  localparam int          EV_WDT        = 3;
  localparam int          EV_RI         = 4;
  localparam int          EV_OVF        = 5;
  localparam int          EV_UNF        = 6;
  localparam int          EV_WAKE       = 7;

  // ==========================================================
  // program counter targets
  localparam int          PC_W          = 15;
  localparam logic [14:0] PC_RESTART    = 15'h0000;
  localparam logic [14:0] PC_INT_VECTOR = 15'h0004;

endpackage

// [rcr_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module rcr_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_async,
  output logic      o_sync
);

  // ==========================================================
  // two-stage synchroniser
  logic meta_q;
  logic sync_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule
`default_nettype wire

// [rcr_irq.sv]
`timescale 1ns/100ps
`default_nettype none
module rcr_irq #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_event,
  input  wire logic         i_stat_wr,
  input  wire logic         i_mask_wr,
  input  wire logic [W-1:0] i_wdata,
  output logic      [W-1:0] o_status,
  output logic      [W-1:0] o_mask,
  output logic              o_irq
);

  // ==========================================================
  // sticky status, write one to clear, set wins
  logic [W-1:0] stat_q;
  logic [W-1:0] stat_d;
  logic [W-1:0] mask_q;
  logic [W-1:0] clr;

  assign clr    = i_stat_wr ? i_wdata : '0;
  assign stat_d = (stat_q & ~clr) | i_event;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      stat_q <= stat_d;
      if (i_mask_wr) begin
        mask_q <= i_wdata;
      end
    end
  end

  assign o_status = stat_q;
  assign o_mask   = mask_q;
  assign o_irq    = |(stat_q & mask_q);

endmodule
`default_nettype wire

// [rcr_top.sv]
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module rcr_top #(
  parameter int PCW = rcr_pkg::PC_W
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  // reset and wake sources
  input  wire logic                      i_por_evt,
  input  wire logic                      i_bor_evt,
  input  wire logic                      i_external_reset_pin_n,
  input  wire logic                      i_wdt_evt,
  input  wire logic                      i_reset_instr_evt,
  input  wire logic                      i_stack_ovf_evt,
  input  wire logic                      i_stack_unf_evt,
  input  wire logic                      i_int_wake_evt,
  // core state and configuration
  input  wire logic                      i_sleeping,
  input  wire logic                      i_global_int_enable,
  input  wire logic [PCW-1:0]            i_pc,
  input  wire logic                      i_stack_reset_enable,
  input  wire logic [1:0]                i_brownout_mode_cfg,
  input  wire logic                      i_brownout_active,
  // register port
  input  wire logic [rcr_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [7:0]                i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [7:0]                o_rdata,
  // restart towards the core
  output logic                           o_restart,
  output logic      [PCW-1:0]            o_restart_pc,
  output logic                           o_int_vector_req,
  output logic      [PCW-1:0]            o_int_vector,
  output logic                           o_alu_flags_clear,
  output logic                           o_timeout_flag_n,
  output logic                           o_powerdown_flag_n,
  output logic                           o_brownout_detect_en,
  output logic                           o_irq
);

  // ==========================================================
  // pin inputs
  logic ext_pin_s;
  logic ext_pin_q;
  logic ready_s;

  rcr_sync #(
    .RST_VAL (1'b1)
  ) u_sync_ext (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_external_reset_pin_n),
    .o_sync    (ext_pin_s)
  );

  rcr_sync #(
    .RST_VAL (1'b0)
  ) u_sync_rdy (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_brownout_active),
    .o_sync    (ready_s)
  );

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_pin_q <= 1'b1;
    end else begin
      ext_pin_q <= ext_pin_s;
    end
  end

  // ==========================================================
  // event decode by priority, one source per cycle except wake with instruction or stack events
  logic ev_ext;
  logic ev_por;
  logic ev_bor;
  logic ev_pin;
  logic ev_wdt;
  logic ev_ri;
  logic ev_ovf;
  logic ev_unf;
  logic ev_wake;
  logic ev_pin_run;
  logic ev_pin_slp;
  logic ev_wdt_run;
  logic ev_wdt_slp;
  logic ev_restart;
  logic ev_resume;

  // pin assertion edge becomes a single pulse
  assign ev_ext = ext_pin_q & ~ext_pin_s;

  assign ev_por = i_por_evt;
  assign ev_bor = i_bor_evt & ~ev_por;
  assign ev_pin = ev_ext & ~ev_por & ~ev_bor;
  assign ev_wdt = i_wdt_evt & ~ev_por & ~ev_bor & ~ev_pin;
  assign ev_ri  = i_reset_instr_evt & ~ev_por & ~ev_bor
                & ~ev_pin & ~ev_wdt;
  assign ev_ovf = i_stack_ovf_evt & i_stack_reset_enable
                & ~ev_por & ~ev_bor & ~ev_pin & ~ev_wdt
                & ~ev_ri;
  assign ev_unf = i_stack_unf_evt & i_stack_reset_enable
                & ~ev_por & ~ev_bor & ~ev_pin & ~ev_wdt
                & ~ev_ri & ~ev_ovf;
  assign ev_wake = i_int_wake_evt & i_sleeping
                 & ~ev_por & ~ev_bor & ~ev_pin & ~ev_wdt;

  assign ev_pin_run = ev_pin & ~i_sleeping;
  assign ev_pin_slp = ev_pin & i_sleeping;
  assign ev_wdt_run = ev_wdt & ~i_sleeping;
  assign ev_wdt_slp = ev_wdt & i_sleeping;

  assign ev_restart = ev_por | ev_bor | ev_pin | ev_wdt_run
                    | ev_ri | ev_ovf | ev_unf;
  assign ev_resume  = ev_wdt_slp | ev_wake;

  // ==========================================================
  // register decode
  logic wr_bc;
  logic wr_cf;
  logic wr_ist;
  logic wr_imk;

  assign wr_bc  = i_wr & (i_addr == rcr_pkg::OFF_BOR_CTRL);
  assign wr_cf  = i_wr & (i_addr == rcr_pkg::OFF_CAUSE);
  assign wr_ist = i_wr & (i_addr == rcr_pkg::OFF_IRQ_STAT);
  assign wr_imk = i_wr & (i_addr == rcr_pkg::OFF_IRQ_MASK);

  // ==========================================================
  // cause flags
  logic [7:0] cause_q;
  logic [7:0] cause_d;
  logic [7:0] cause_sw;

  // software may write any flag, active or not, with no reset action
  assign cause_sw = wr_cf ? (i_wdata & rcr_pkg::CF_IMPL_MASK)
                          : cause_q;

  // hardware update overrides the write, and only its own bits
  always_comb begin
    cause_d = cause_sw;
    if (ev_por) begin
      cause_d[rcr_pkg::CF_OVF]   = 1'b0;
      cause_d[rcr_pkg::CF_UNF]   = 1'b0;
      cause_d[rcr_pkg::CF_WDT_N] = 1'b1;
      cause_d[rcr_pkg::CF_EXT_N] = 1'b1;
      cause_d[rcr_pkg::CF_RI_N]  = 1'b1;
      cause_d[rcr_pkg::CF_POR_N] = 1'b0;
    end else if (ev_bor) begin
      cause_d[rcr_pkg::CF_OVF]   = 1'b0;
      cause_d[rcr_pkg::CF_UNF]   = 1'b0;
      cause_d[rcr_pkg::CF_WDT_N] = 1'b1;
      cause_d[rcr_pkg::CF_EXT_N] = 1'b1;
      cause_d[rcr_pkg::CF_RI_N]  = 1'b1;
      cause_d[rcr_pkg::CF_BOR_N] = 1'b0;
    end else if (ev_pin) begin
      cause_d[rcr_pkg::CF_EXT_N] = 1'b0;
    end else if (ev_wdt_run) begin
      cause_d[rcr_pkg::CF_WDT_N] = 1'b0;
    end else if (ev_ri) begin
      cause_d[rcr_pkg::CF_RI_N]  = 1'b0;
    end else if (ev_ovf) begin
      cause_d[rcr_pkg::CF_OVF]   = 1'b1;
    end else if (ev_unf) begin
      cause_d[rcr_pkg::CF_UNF]   = 1'b1;
    end
    // other flags keep their value; only power-on and brown-out return flags inactive
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cause_q <= rcr_pkg::CF_RST;
    end else begin
      cause_q <= cause_d;
    end
  end

  // ==========================================================
  // timeout and powerdown status bits
  logic to_q;
  logic to_d;
  logic pd_q;
  logic pd_d;

  always_comb begin
    to_d = to_q;
    pd_d = pd_q;
    if (ev_por | ev_bor) begin
      to_d = 1'b1;
      pd_d = 1'b1;
    end else if (ev_pin_slp) begin
      to_d = 1'b1;
      pd_d = 1'b0;
    end else if (ev_wdt_run) begin
      to_d = 1'b0;
    end else if (ev_wdt_slp) begin
      to_d = 1'b0;
      pd_d = 1'b0;
    end else if (ev_wake) begin
      to_d = 1'b1;
      pd_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else begin
      to_q <= to_d;
      pd_q <= pd_d;
    end
  end

  assign o_timeout_flag_n   = to_q;
  assign o_powerdown_flag_n = pd_q;

  // ==========================================================
  // restart point towards the core
  logic           restart_q;
  logic [PCW-1:0] restart_pc_q;
  logic [PCW-1:0] restart_pc_d;
  logic           vec_q;
  logic           alu_clr_q;
  logic [PCW-1:0] pc_next;

  assign pc_next = i_pc + PCW'(1);

  // resets start at the restart address, wake-ups at the next word
  assign restart_pc_d = ev_restart ? PCW'(rcr_pkg::PC_RESTART)
                      : pc_next;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      restart_q    <= 1'b0;
      restart_pc_q <= '0;
      vec_q        <= 1'b0;
      alu_clr_q    <= 1'b0;
    end else begin
      restart_q <= ev_restart | ev_resume;
      if (ev_restart | ev_resume) begin
        restart_pc_q <= restart_pc_d;
      end
      vec_q     <= ev_wake & i_global_int_enable;
      alu_clr_q <= ev_por | ev_bor;
    end
  end

  assign o_restart         = restart_q;
  assign o_restart_pc      = restart_pc_q;
  assign o_int_vector_req  = vec_q;
  assign o_int_vector      = PCW'(rcr_pkg::PC_INT_VECTOR);
  assign o_alu_flags_clear = alu_clr_q;

  // ==========================================================
  // brown-out control
  logic sw_brownout_enable_q;
  logic rsvd_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sw_brownout_enable_q <= rcr_pkg::BC_SW_EN_RST;
      rsvd_q               <= rcr_pkg::BC_RSVD_RST;
    end else if (ev_por | ev_bor) begin
      sw_brownout_enable_q <= rcr_pkg::BC_SW_EN_RST;
      rsvd_q               <= rcr_pkg::BC_RSVD_RST;
    end else if (wr_bc) begin
      sw_brownout_enable_q <= i_wdata[rcr_pkg::BC_SW_EN];
      rsvd_q               <= i_wdata[rcr_pkg::BC_RSVD];
    end
  end

  logic [1:0] bmode;
  assign bmode = i_brownout_mode_cfg;

  assign o_brownout_detect_en =
      (bmode == rcr_pkg::BMODE_ON)
    | ((bmode == rcr_pkg::BMODE_NOSLEEP) & ~i_sleeping)
    | ((bmode == rcr_pkg::BMODE_SW) & sw_brownout_enable_q);

  // ==========================================================
  // interrupt events
  logic [rcr_pkg::EV_W-1:0] evec;
  logic [rcr_pkg::EV_W-1:0] ist;
  logic [rcr_pkg::EV_W-1:0] imk;

  always_comb begin
    evec                   = '0;
    evec[rcr_pkg::EV_POR]  = ev_por;
    evec[rcr_pkg::EV_BOR]  = ev_bor;
    evec[rcr_pkg::EV_EXT]  = ev_pin;
    evec[rcr_pkg::EV_WDT]  = ev_wdt;
    evec[rcr_pkg::EV_RI]   = ev_ri;
    evec[rcr_pkg::EV_OVF]  = ev_ovf;
    evec[rcr_pkg::EV_UNF]  = ev_unf;
    evec[rcr_pkg::EV_WAKE] = ev_wake;
  end

  rcr_irq #(
    .W (rcr_pkg::EV_W)
  ) u_irq (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_event   (evec),
    .i_stat_wr (wr_ist),
    .i_mask_wr (wr_imk),
    .i_wdata   (i_wdata),
    .o_status  (ist),
    .o_mask    (imk),
    .o_irq     (o_irq)
  );

  // ==========================================================
  // read data, one cycle after the strobe
  logic [7:0] bc_rd;
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;

  always_comb begin
    bc_rd                   = '0;
    bc_rd[rcr_pkg::BC_SW_EN] = sw_brownout_enable_q;
    bc_rd[rcr_pkg::BC_RSVD]  = rsvd_q;
    bc_rd[rcr_pkg::BC_READY] = ready_s;
  end

  assign rd_mux =
      (i_addr == rcr_pkg::OFF_BOR_CTRL) ? bc_rd
    : (i_addr == rcr_pkg::OFF_CAUSE)
      ? (cause_q & rcr_pkg::CF_IMPL_MASK)
    : (i_addr == rcr_pkg::OFF_IRQ_STAT) ? ist
    : (i_addr == rcr_pkg::OFF_IRQ_MASK) ? imk
    : 8'h00;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;

endmodule
`default_nettype wire

// [rcr_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module rcr_checker #(
  parameter int PCW = rcr_pkg::PC_W
) (
  input wire logic                       i_clk,
  input wire logic                       i_reset_n,
  input wire logic                       i_por_evt,
  input wire logic                       i_bor_evt,
  input wire logic                       i_external_reset_pin_n,
  input wire logic                       i_wdt_evt,
  input wire logic                       i_reset_instr_evt,
  input wire logic                       i_stack_ovf_evt,
  input wire logic                       i_stack_unf_evt,
  input wire logic                       i_int_wake_evt,
  input wire logic                       i_sleeping,
  input wire logic                       i_global_int_enable,
  input wire logic [PCW-1:0]             i_pc,
  input wire logic                       i_stack_reset_enable,
  input wire logic [1:0]                 i_brownout_mode_cfg,
  input wire logic                       i_brownout_active,
  input wire logic [rcr_pkg::ADDR_W-1:0] i_addr,
  input wire logic                       i_rd,
  input wire logic [7:0]                 o_rdata,
  input wire logic                       o_restart,
  input wire logic [PCW-1:0]             o_restart_pc,
  input wire logic                       o_int_vector_req,
  input wire logic                       o_alu_flags_clear,
  input wire logic                       o_timeout_flag_n,
  input wire logic                       o_powerdown_flag_n,
  input wire logic                       o_brownout_detect_en
);
  // ==========================================================
  // helper logic: one event alone, pin quiet for its sync depth
  logic [3:0] pin_q;
  logic [6:0] evts;
  logic       solo;
  assign evts = {i_int_wake_evt, i_stack_unf_evt, i_stack_ovf_evt,
                 i_reset_instr_evt, i_wdt_evt, i_bor_evt, i_por_evt};
  assign solo = (&pin_q) && i_external_reset_pin_n && $onehot(evts);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_q <= 4'hf;
    end else begin
      pin_q <= {pin_q[2:0], i_external_reset_pin_n};
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // ==========================================================
  // properties
  property p_pwr;
    (i_por_evt || i_bor_evt) |=> o_restart && o_alu_flags_clear
      && o_restart_pc == rcr_pkg::PC_RESTART
      && o_timeout_flag_n && o_powerdown_flag_n;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power reset state");
  property p_wdt_run;
    solo && i_wdt_evt && !i_sleeping |=> o_restart && !o_timeout_flag_n
      && o_restart_pc == rcr_pkg::PC_RESTART && $stable(o_powerdown_flag_n);
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("watchdog run");
  property p_wdt_slp;
    solo && i_wdt_evt && i_sleeping |=> !o_timeout_flag_n
      && !o_powerdown_flag_n && o_restart_pc == $past(i_pc) + 1'b1;
  endproperty
  a_wdt_slp: assert property (p_wdt_slp) else $error("watchdog wake");
  property p_wake;
    solo && i_int_wake_evt && i_sleeping |=> o_timeout_flag_n
      && !o_powerdown_flag_n && o_restart_pc == $past(i_pc) + 1'b1
      && o_int_vector_req == $past(i_global_int_enable);
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt wake");
  property p_instr;
    solo && i_reset_instr_evt |=> o_restart && !o_alu_flags_clear
      && $stable(o_timeout_flag_n) && $stable(o_powerdown_flag_n);
  endproperty
  a_instr: assert property (p_instr) else $error("reset instr");
  property p_stk_off;
    solo && !i_stack_reset_enable && (i_stack_ovf_evt || i_stack_unf_evt)
      |=> !o_restart;
  endproperty
  a_stk_off: assert property (p_stk_off) else $error("stack ignored");
  property p_rd_zero;
    i_rd && i_addr == rcr_pkg::OFF_BOR_CTRL |=> o_rdata[5:1] == 5'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unimpl bits");
  property p_ready;
    i_brownout_active [*3] ##0 (i_rd && i_addr == rcr_pkg::OFF_BOR_CTRL)
      |=> o_rdata[0];
  endproperty
  a_ready: assert property (p_ready) else $error("ready bit");
  property p_bor_cfg;
    (i_brownout_mode_cfg == rcr_pkg::BMODE_OFF |-> !o_brownout_detect_en)
      and (i_brownout_mode_cfg == rcr_pkg::BMODE_ON |-> o_brownout_detect_en);
  endproperty
  a_bor_cfg: assert property (p_bor_cfg) else $error("detect enable");
endmodule
bind rcr_top rcr_checker #(.PCW(PCW)) u_chk (.*);
`default_nettype wire

// [tb_reset_cause_recorder.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_reset_cause_recorder;
  logic        i_clk, i_reset_n, pin_n, sl, global_int_enable, stk_en, bo_act, wr, rd;
  logic        to_m, pd_m, o_restart, o_int_vector_req, o_alu_flags_clear;
  logic        o_timeout_flag_n, o_powerdown_flag_n, o_brownout_detect_en;
  logic        o_irq;
  logic [7:0]  ev, wd, rdv, cause_m, wv, o_rdata;
  logic [14:0] pc, o_restart_pc, o_int_vector;
  logic [1:0]  cfg;
  logic [2:0]  addr;
  int          fails, samples_checked;

  rcr_top dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_por_evt(ev[0]),
    .i_bor_evt(ev[1]), .i_external_reset_pin_n(pin_n), .i_wdt_evt(ev[3]),
    .i_reset_instr_evt(ev[4]), .i_stack_ovf_evt(ev[5]),
    .i_stack_unf_evt(ev[6]), .i_int_wake_evt(ev[7]), .i_sleeping(sl),
    .i_global_int_enable(global_int_enable), .i_pc(pc), .i_stack_reset_enable(stk_en),
    .i_brownout_mode_cfg(cfg), .i_brownout_active(bo_act), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(o_rdata),
    .o_restart(o_restart), .o_restart_pc(o_restart_pc),
    .o_int_vector_req(o_int_vector_req), .o_int_vector(o_int_vector),
    .o_alu_flags_clear(o_alu_flags_clear),
    .o_timeout_flag_n(o_timeout_flag_n),
    .o_powerdown_flag_n(o_powerdown_flag_n),
    .o_brownout_detect_en(o_brownout_detect_en), .o_irq(o_irq)
  );

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    rdv = o_rdata;
  endtask
  // cause flags after event k (0 por .. 7 wake)
  function automatic logic [7:0] nxt(input logic [7:0] c, input int k,
                                     input logic s, input logic en);
    case (k)
      0: return 8'h1c | (c & 8'h01);
      1: return 8'h1c | (c & 8'h02);
      2: return c & 8'hf7;
      3: return s ? c : c & 8'hef;
      4: return c & 8'hfb;
      5: return en ? c | 8'h80 : c;
      6: return en ? c | 8'h40 : c;
      default: return c;
    endcase
  endfunction
  task automatic fire(input int k);
    logic        act, rs;
    logic [14:0] pe;
    @(posedge i_clk);
    act = !((k == 5 || k == 6) && !stk_en) && !(k == 7 && !sl);
    rs = 1'b0;
    if (k == 2) begin
      pin_n <= 1'b0;
      for (int i = 0; i < 6 && !rs; i++) begin
        @(posedge i_clk);
        #1;
        rs = o_restart;
      end
      pin_n <= 1'b1;
      if (!rs) begin
        fails++;
        finish_test();
      end
    end else begin
      pc <= 15'($urandom);
      ev <= 8'h01 << k;
      @(posedge i_clk);
      ev <= 8'h00;
      #1;
      rs = o_restart;
    end
    pe = (k == 7 || (k == 3 && sl)) ? pc + 15'h1 : 15'h0;
    if (k < 2 || (sl && (k == 2 || k == 7))) to_m = 1'b1;
    if (k == 3) to_m = 1'b0;
    if (k < 2) pd_m = 1'b1;
    if (sl && (k == 2 || k == 3 || k == 7)) pd_m = 1'b0;
    chk(rs, act);
    if (act) begin
      chk(o_restart_pc, pe);
      chk({o_timeout_flag_n, o_powerdown_flag_n}, {to_m, pd_m});
      chk(o_alu_flags_clear, k < 2);
      if (k == 7) chk({o_int_vector_req, o_int_vector}, {global_int_enable, 15'h4});
    end
    cause_m = nxt(cause_m, k, sl, stk_en);
    rd_reg(rcr_pkg::OFF_CAUSE);
    chk(rdv, cause_m);
  endtask

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h6a55));
    {i_reset_n, pin_n, sl, global_int_enable, stk_en, bo_act, wr, rd} = 8'h44;
    {ev, wd, pc, cfg, addr} = 36'h0;
    {fails, samples_checked} = 64'h0;
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    {cause_m, to_m, pd_m} = 10'h077;
    rd_reg(rcr_pkg::OFF_CAUSE);
    chk(rdv, 8'h1d);
    wr_reg(rcr_pkg::OFF_BOR_CTRL, 8'hbe);
    rd_reg(rcr_pkg::OFF_BOR_CTRL);
    chk(rdv, 8'h81);
    for (int m = 0; m < 8; m++) begin
      wr_reg(rcr_pkg::OFF_BOR_CTRL, {m[0], 7'h00});
      cfg <= m[2:1];
      sl <= 1'($urandom);
      @(posedge i_clk);
      #1;
      chk(o_brownout_detect_en, cfg == 2'h3 || (cfg == 2'h1 && m[0])
          || (cfg == 2'h2 && !sl));
      rd_reg(rcr_pkg::OFF_BOR_CTRL);
      chk(rdv, {m[0], 7'h01});
    end
    bo_act <= 1'b0;
    repeat (3) @(posedge i_clk);
    rd_reg(rcr_pkg::OFF_BOR_CTRL);
    chk(rdv[0], 1'b0);
    bo_act <= 1'b1;
    rd_reg(3'h5);
    chk(rdv, 8'h00);
    wr_reg(3'h6, 8'h00);
    wr_reg(rcr_pkg::OFF_IRQ_MASK, 8'h00);
    wr_reg(rcr_pkg::OFF_IRQ_STAT, 8'hff);
    for (int k = 0; k < 16; k++) begin
      sl <= k[3];
      global_int_enable <= k[3];
      stk_en <= 1'b1;
      fire(k % 8);
    end
    wr_reg(rcr_pkg::OFF_IRQ_STAT, 8'hff);
    sl <= 1'b0;
    fire(4);
    rd_reg(rcr_pkg::OFF_IRQ_STAT);
    chk({o_irq, rdv}, 9'h010);
    wr_reg(rcr_pkg::OFF_IRQ_MASK, 8'h10);
    #1;
    chk(o_irq, 1'b1);
    wr_reg(rcr_pkg::OFF_IRQ_STAT, 8'h10);
    #1;
    chk(o_irq, 1'b0);
    for (int n = 0; n < 40; n++) begin
      sl <= 1'($urandom);
      stk_en <= 1'($urandom);
      global_int_enable <= 1'($urandom);
      fire(int'($urandom % 8));
    end
    for (int n = 0; n < 4; n++) begin
      wv = 8'($urandom) & rcr_pkg::CF_IMPL_MASK;
      wr_reg(rcr_pkg::OFF_CAUSE, wv);
      #1;
      chk(o_restart, 1'b0);
      rd_reg(rcr_pkg::OFF_CAUSE);
      chk(rdv, wv);
    end
    @(posedge i_clk);
    addr <= rcr_pkg::OFF_CAUSE;
    wd <= 8'hdf;
    wr <= 1'b1;
    ev <= 8'h10;
    @(posedge i_clk);
    wr <= 1'b0;
    ev <= 8'h00;
    rd_reg(rcr_pkg::OFF_CAUSE);
    chk(rdv, 8'hdb);
    finish_test();
  end
endmodule
`default_nettype wire
